// ### shared/flag_unit_defines.svh
// Purpose: constants for the flag register and sense switch test unit
// Assumes: 24-bit instruction word, bit 0 is the most significant bit
// Notes: bit numbers below are hardware bit indices (bit 0 = LSB)
`ifndef FLAG_UNIT_DEFINES_SVH
`define FLAG_UNIT_DEFINES_SVH

`define WORD_W 24
`define FLAG_W 6
`define PC_W 15
// Hardware bit indices of the word (bit n of the doc = [23-n])
`define MODE_BIT 14
`define RTEST_BIT 13
`define STEST_BIT 12
`define RMASK_HI 11
`define RMASK_LO 6
`define SMASK_HI 5
`define SMASK_LO 0
`define FLAG_RESET 6'h00
`define PC_RESET 15'h0000
`define PC_STEP 15'h0001
`define PC_SKIP 15'h0002
// Register map
`define ADDR_CTRL 32'h00
`define ADDR_INSN 32'h04
`define ADDR_STATUS 32'h08
`define ADDR_PC 32'h0C
`define ADDR_SWITCH 32'h10
`define CTRL_GO_BIT 0
`define CTRL_REPEAT_BIT 1
`define CTRL_VARIANT_LO 2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### shared/flag_unit_pkg.sv
// Purpose: types for the flag register and sense switch test unit
// Assumes: constants come from flag_unit_defines.svh
// Notes: variant codes are chosen by software in the control register
`include "flag_unit_defines.svh"
`default_nettype none
package flag_unit_pkg;
  typedef enum logic [1:0] {
    flag_reset_set = 2'h0,
    flag_set_test_reset = 2'h1,
    flag_reset_test_set = 2'h2
  } variant_e;
  typedef enum logic [1:0] {
    st_idle = 2'h0,
    st_exec = 2'h1,
    st_skip = 2'h2
  } exec_state_e;
  typedef struct packed {
    logic mode_switch;
    logic comb_reset;
    logic comb_set;
    logic [`FLAG_W-1:0] reset_mask;
    logic [`FLAG_W-1:0] set_mask;
  } insn_fields_s;
endpackage
`default_nettype wire

// ### hw/switch_sync.sv
// Purpose: three-stage synchroniser with agreement filter for sense switches
// Assumes: switches are asynchronous to clk_i
// Notes: output changes only once stages two and three agree
`include "flag_unit_defines.svh"
`default_nettype none
module switch_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Raw and filtered switches
  input wire logic [`FLAG_W-1:0] raw_i,
  output logic [`FLAG_W-1:0] clean_o
);
  logic [`FLAG_W-1:0] s1, s2, s3, clean;
  logic [`FLAG_W-1:0] next_clean;

  // Accept a new level only when the last two stages agree
  always_comb begin
    next_clean = clean;
    for (int i = 0; i < `FLAG_W; i++) begin
      if (s2[i] == s3[i]) begin
        next_clean[i] = s3[i];
      end
    end
  end

  // First stage feeds only the second stage
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1 <= 6'h00;
      s2 <= 6'h00;
      s3 <= 6'h00;
      clean <= 6'h00;
    end else begin
      s1 <= raw_i;
      s2 <= s1;
      s3 <= s2;
      clean <= next_clean;
    end
  end

  assign clean_o = clean;
endmodule // switch_sync
`default_nettype wire

// ### hw/flag_unit.sv
// Purpose: flag register control and sense switch test execution unit
// Assumes: AXI4-Lite slave; software loads an instruction word and starts it
// Notes: one cycle per operation, a second cycle when a skip advances the PC
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`include "flag_unit_defines.svh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module flag_unit
  import flag_unit_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // AXI4-Lite write channels
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Console
  input wire logic [`FLAG_W-1:0] sense_switch_i,
  output logic [`FLAG_W-1:0] flag_lamp_o,
  output logic overflow_o,
  output logic busy_o
);

  // Field decode used by the execution path and the assertions
  function automatic insn_fields_s decode(input logic [`WORD_W-1:0] w);
    insn_fields_s f;
    f.mode_switch = w[`MODE_BIT];
    f.comb_reset = w[`RTEST_BIT];
    f.comb_set = w[`STEST_BIT];
    // Doc bit 12 is hardware bit 11; flag one sits at lamp index 0
    for (int i = 0; i < `FLAG_W; i++) begin
      f.reset_mask[i] = w[`RMASK_HI - i];
      f.set_mask[i] = w[`SMASK_HI - i];
    end
    return f;
  endfunction

  logic [`FLAG_W-1:0] switches;
  logic [`FLAG_W-1:0] flags, next_flags;
  logic [`PC_W-1:0] pc, next_pc;
  logic [`WORD_W-1:0] insn, next_insn;
  variant_e variant, next_variant;
  exec_state_e state, next_state;
  logic skip_flag, next_skip_flag;
  logic refused, next_refused;
  logic go_pulse, repeat_req;
  variant_e go_variant;
  insn_fields_s f;
  logic skip_now;
  logic [`FLAG_W-1:0] exec_flags;

  switch_sync u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .raw_i(sense_switch_i),
    .clean_o(switches)
  );

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: address and data taken in either order
  logic aw_held, w_held, next_aw_held, next_w_held;
  logic [31:0] aw_addr, next_aw_addr, w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic do_write;

  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign arready = !rvalid;
  assign do_write = aw_held && w_held && !bvalid;

  // Bus next-state; register writes are applied in the execution block
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      unique case (aw_addr)
        `ADDR_CTRL, `ADDR_INSN, `ADDR_STATUS, `ADDR_PC, `ADDR_SWITCH: next_bresp = `RESP_OKAY;
        default: next_bresp = `RESP_SLVERR;
      endcase
    end else if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp = `RESP_OKAY;
      unique case (araddr)
        `ADDR_CTRL: next_rdata = {28'h0000000, variant, 2'h0};
        `ADDR_INSN: next_rdata = {8'h00, insn};
        `ADDR_STATUS: next_rdata = {22'h000000, refused, skip_flag, busy_o, state == st_skip, flags};
        `ADDR_PC: next_rdata = {17'h00000, pc};
        `ADDR_SWITCH: next_rdata = {26'h0000000, switches};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = `RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
  end

  // Bus registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 32'h00000000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      rvalid <= 1'b0;
      rresp <= 2'h0;
      rdata <= 32'h00000000;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  // Control write: go bit starts, repeat bit marks a repeat attempt
  assign go_pulse = do_write && aw_addr == `ADDR_CTRL && w_strb[0] && w_data[`CTRL_GO_BIT];
  assign repeat_req = w_data[`CTRL_REPEAT_BIT];
  assign go_variant = variant_e'(w_data[`CTRL_VARIANT_LO +: 2]);

  //////////////////////////////////////////////////////////////////////////////
  // Execution
  assign f = decode(insn);

  // Skip decision and flag update of the operation in flight
  always_comb begin
    logic any_hit;
    any_hit = 1'b0;
    exec_flags = flags;
    if (f.mode_switch) begin
      // Merged test: any satisfied condition suppresses the skip
      any_hit = |(switches & f.set_mask) | |(~switches & f.reset_mask);
      if (f.comb_reset) begin
        any_hit = any_hit | |(~flags & f.reset_mask);
      end
      if (f.comb_set) begin
        any_hit = any_hit | |(flags & f.set_mask);
      end
      exec_flags = flags;
    end else begin
      unique case (variant)
        flag_reset_set: begin
          any_hit = 1'b1;
          // Both masks toggle, one mask forces
          exec_flags = (flags & ~f.reset_mask & ~f.set_mask) | (f.set_mask & ~f.reset_mask)
                       | (~flags & f.reset_mask & f.set_mask);
        end
        flag_set_test_reset: begin
          any_hit = |(flags & f.set_mask);
          exec_flags = flags & ~f.reset_mask;
        end
        flag_reset_test_set: begin
          any_hit = |(~flags & f.reset_mask);
          exec_flags = flags | f.set_mask;
        end
        default: begin
          any_hit = 1'b1;
          exec_flags = flags;
        end
      endcase
    end
    skip_now = !any_hit;
  end

  // Sequencer, flags, PC and software-written registers
  always_comb begin
    next_state = state;
    next_flags = flags;
    next_pc = pc;
    next_insn = insn;
    next_variant = variant;
    next_skip_flag = skip_flag;
    next_refused = refused;
    if (do_write && aw_addr == `ADDR_INSN && state == st_idle) begin
      next_insn = w_data[`WORD_W-1:0];
    end
    if (do_write && aw_addr == `ADDR_PC && state == st_idle) begin
      next_pc = w_data[`PC_W-1:0];
    end
    if (do_write && aw_addr == `ADDR_STATUS && w_data[9]) begin
      next_refused = 1'b0;
    end
    unique case (state)
      st_idle: begin
        if (go_pulse && repeat_req) begin
          next_refused = 1'b1;
        end else if (go_pulse) begin
          next_variant = go_variant;
          next_state = st_exec;
        end
      end
      st_exec: begin
        next_flags = exec_flags;
        next_skip_flag = skip_now;
        if (skip_now) begin
          next_state = st_skip;
        end else begin
          next_pc = pc + `PC_STEP;
          next_state = st_idle;
        end
      end
      st_skip: begin
        next_pc = pc + `PC_SKIP;
        next_state = st_idle;
      end
      default: next_state = st_idle;
    endcase
  end

  // Execution registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= st_idle;
      flags <= `FLAG_RESET;
      pc <= `PC_RESET;
      insn <= 24'h000000;
      variant <= flag_reset_set;
      skip_flag <= 1'b0;
      refused <= 1'b0;
    end else begin
      state <= next_state;
      flags <= next_flags;
      pc <= next_pc;
      insn <= next_insn;
      variant <= next_variant;
      skip_flag <= next_skip_flag;
      refused <= next_refused;
    end
  end

  // Lamps come straight from the flag flops; index 0 is overflow, so no glitch reaches the console
  assign flag_lamp_o = flags;
  assign overflow_o = flags[0];
  assign busy_o = state != st_idle;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_exec_skip;
    state == st_exec && skip_now;
  endsequence

  property p_skip_two_cycles;
    @(posedge clk_i) disable iff (!reset_n_i)
      s_exec_skip |=> state == st_skip ##1 (state == st_idle && pc == $past(pc, 2) + `PC_SKIP);
  endproperty
  a_skip_two_cycles: assert property (p_skip_two_cycles) else $error("skip not two cycles");

  property p_noskip_one;
    @(posedge clk_i) disable iff (!reset_n_i)
      state == st_exec && !skip_now |=> state == st_idle && pc == $past(pc) + `PC_STEP;
  endproperty
  a_noskip_one: assert property (p_noskip_one) else $error("no-skip not one cycle");

  property p_switch_keeps_flags;
    @(posedge clk_i) disable iff (!reset_n_i)
      state == st_exec && f.mode_switch |=> $stable(flags);
  endproperty
  a_switch_keeps_flags: assert property (p_switch_keeps_flags) else $error("switch mode changed flags");

  property p_repeat_refused;
    @(posedge clk_i) disable iff (!reset_n_i)
      state == st_idle && go_pulse && repeat_req |=> state == st_idle && refused;
  endproperty
  a_repeat_refused: assert property (p_repeat_refused) else $error("repeat accepted");

  property p_set_reset;
    @(posedge clk_i) disable iff (!reset_n_i)
      state == st_exec && !f.mode_switch && variant == flag_reset_set
      |=> (flags & ($past(f.set_mask) ^ $past(f.reset_mask))) == ($past(f.set_mask) & ~$past(f.reset_mask));
  endproperty
  a_set_reset: assert property (p_set_reset) else $error("set/reset wrong");

  property p_toggle;
    @(posedge clk_i) disable iff (!reset_n_i)
      state == st_exec && !f.mode_switch && variant == flag_reset_set
      |=> ((flags ^ $past(flags)) & $past(f.set_mask & f.reset_mask)) == $past(f.set_mask & f.reset_mask);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle wrong");

  property p_set_test;
    @(posedge clk_i) disable iff (!reset_n_i)
      state == st_exec && !f.mode_switch && variant == flag_set_test_reset
      |=> (state == st_skip) == ($past(flags & f.set_mask) == 6'h00);
  endproperty
  a_set_test: assert property (p_set_test) else $error("set test wrong");

  property p_test_then_reset;
    @(posedge clk_i) disable iff (!reset_n_i)
      state == st_exec && !f.mode_switch && variant == flag_set_test_reset
      |=> (flags & $past(f.reset_mask)) == 6'h00;
  endproperty
  a_test_then_reset: assert property (p_test_then_reset) else $error("reset after test missing");

  property p_lamps;
    @(posedge clk_i) disable iff (!reset_n_i)
      state != st_exec |=> $stable(flag_lamp_o) && overflow_o == flag_lamp_o[0];
  endproperty
  a_lamps: assert property (p_lamps) else $error("lamps disagree with flags");

endmodule // flag_unit
`default_nettype wire

// ### tb/sense_console.sv
// Purpose: console sense switch panel facing the flag unit
// Assumes: switches are steady levels commanded by the bench
// Notes: no contact bounce is modelled, so only the synchroniser delay shows
`default_nettype none
module sense_console (
  // Commanded positions
  input wire logic [5:0] pos_i,
  // Switch contacts
  output logic [5:0] switch_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // A switch holds its level until the operator moves it
  assign switch_o = pos_i;
endmodule // sense_console
`default_nettype wire

// ### tb/flag_unit_tb_top.sv
// Purpose: self-checking bench for the flag and sense switch unit
// Assumes: each bus answer comes within 50 cycles
// Notes: expected flags and program counter are tracked from the fields
`include "flag_unit_defines.svh"
`default_nettype none
module flag_unit_tb_top
  import flag_unit_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rv;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ovf, busy;
  logic [1:0] bresp, rresp, rr;
  logic [5:0] sw_pos = 6'h00, sense_sw, lamp, ef;
  logic [14:0] ep;
  int n_fail = 0;
  int cmp_count = 0;
  ////////////////////////////////////////
  // Unit under test and console panel
  flag_unit dut (.clk_i, .reset_n_i, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .sense_switch_i(sense_sw), .flag_lamp_o(lamp), .overflow_o(ovf), .busy_o(busy));
  sense_console con (.pos_i(sw_pos), .switch_o(sense_sw));
  // 40 MHz clock
  initial forever #12.5 clk_i = ~clk_i;
  ////////////////////////////////////////
  task chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Handshakes are judged at the falling edge, so the next rising edge moves them
  task wr(input logic [31:0] a, d);
    logic ta, tw, done;
    done = 1'b0;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 50 && !done; i++) begin
      @(negedge clk_i);
      ta = awvalid && awready;
      tw = wvalid && wready;
      done = bvalid;
      rr = bresp;
      @(posedge clk_i);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk({31'h0, done}, 32'h1);
  endtask
  task rd(input logic [31:0] a);
    logic ta, done;
    done = 1'b0;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 50 && !done; i++) begin
      @(negedge clk_i);
      ta = arvalid && arready;
      done = rvalid;
      rv = rdata;
      rr = rresp;
      @(posedge clk_i);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk({31'h0, done}, 32'h1);
  endtask
  // One instruction: predict, issue, wait for idle, compare flags, skip and PC
  task op(input variant_e v, input logic m, b10, b11, input logic [5:0] rm, sm);
    logic [23:0] insn;
    logic skip;
    insn = {9'h0, m, b10, b11, 12'h0};
    for (int i = 0; i < 6; i++) begin
      insn[11 - i] = rm[i];
      insn[5 - i] = sm[i];
    end
    if (m) skip = !(|(sw_pos & sm) || |(~sw_pos & rm) || (b11 && |(ef & sm)) || (b10 && |(~ef & rm)));
    else if (v == flag_reset_test_set) skip = !(|(~ef & rm));
    else skip = (v == flag_set_test_reset) && !(|(ef & sm));
    if (!m && v == flag_set_test_reset) ef = ef & ~rm;
    else if (!m && v == flag_reset_test_set) ef = ef | sm;
    else if (!m) ef = (ef & ~(rm | sm)) | (sm & ~rm) | (rm & sm & ~ef);
    ep = ep + (skip ? 15'h2 : 15'h1);
    wr(`ADDR_INSN, {8'h0, insn});
    wr(`ADDR_CTRL, {28'h0, v, 2'h1});
    for (int i = 0; i < 20; i++) begin
      rd(`ADDR_STATUS);
      if (rv[7] === 1'b0) break;
    end
    chk(rv & 32'h13F, {23'h0, skip, 2'h0, ef});
    rd(`ADDR_PC);
    chk(rv & 32'h7FFF, {17'h0, ep});
    chk({25'h0, ovf, lamp}, {25'h0, ef[0], ef});
    chk({31'h0, busy}, 32'h0);
  endtask
  ////////////////////////////////////////
  task t_reset;
    ef = 6'h00;
    ep = 15'h0;
    rd(`ADDR_STATUS);
    chk(rv & 32'h3FF, 32'h0);
    rd(`ADDR_PC);
    chk(rv, 32'h0);
    rd(32'h20);
    chk(rv, 32'h0);
    chk({30'h0, rr}, {30'h0, `RESP_SLVERR});
    wr(32'h24, 32'h1);
    chk({30'h0, rr}, {30'h0, `RESP_SLVERR});
    $display("test reset done");
  endtask
  task t_reset_set;
    op(flag_reset_set, 1'b0, 1'b0, 1'b0, 6'h00, 6'h3F);
    op(flag_reset_set, 1'b0, 1'b0, 1'b0, 6'h15, 6'h00);
    op(flag_reset_set, 1'b0, 1'b0, 1'b0, 6'h33, 6'h0F);
    op(flag_reset_set, 1'b0, 1'b0, 1'b0, 6'h3F, 6'h3F);
    $display("test reset_set done");
  endtask
  // PC starts one below its top so the second step wraps it to zero
  task t_set_test;
    wr(`ADDR_PC, 32'h7FFE);
    ep = 15'h7FFE;
    op(flag_set_test_reset, 1'b0, 1'b0, 1'b0, 6'h01, 6'h20);
    op(flag_set_test_reset, 1'b0, 1'b0, 1'b0, 6'h10, 6'h10);
    op(flag_set_test_reset, 1'b0, 1'b0, 1'b0, 6'h00, 6'h00);
    op(flag_set_test_reset, 1'b0, 1'b0, 1'b0, 6'h3F, 6'h0C);
    op(flag_reset_test_set, 1'b0, 1'b0, 1'b0, 6'h02, 6'h10);
    op(flag_reset_test_set, 1'b0, 1'b0, 1'b0, 6'h00, 6'h01);
    $display("test set_test_reset done");
  endtask
  task t_switch;
    op(flag_reset_set, 1'b0, 1'b0, 1'b0, 6'h00, 6'h21);
    @(posedge clk_i);
    sw_pos <= 6'h05;
    repeat (10) @(posedge clk_i);
    rd(`ADDR_SWITCH);
    chk(rv & 32'h3F, 32'h05);
    op(flag_reset_test_set, 1'b1, 1'b0, 1'b0, 6'h00, 6'h04);
    op(flag_reset_test_set, 1'b1, 1'b0, 1'b0, 6'h00, 6'h02);
    op(flag_reset_test_set, 1'b1, 1'b0, 1'b0, 6'h01, 6'h00);
    op(flag_reset_test_set, 1'b1, 1'b0, 1'b0, 6'h02, 6'h00);
    op(flag_reset_test_set, 1'b1, 1'b0, 1'b1, 6'h00, 6'h20);
    op(flag_reset_test_set, 1'b1, 1'b1, 1'b0, 6'h08, 6'h00);
    op(flag_reset_test_set, 1'b1, 1'b1, 1'b1, 6'h01, 6'h1A);
    $display("test switch done");
  endtask
  task t_refuse;
    wr(`ADDR_INSN, 32'h00003F);
    wr(`ADDR_CTRL, {28'h0, flag_reset_set, 2'h3});
    repeat (4) @(posedge clk_i);
    rd(`ADDR_STATUS);
    chk(rv & 32'h23F, {22'h0, 1'b1, 3'h0, ef});
    rd(`ADDR_PC);
    chk(rv & 32'h7FFF, {17'h0, ep});
    wr(`ADDR_STATUS, 32'h200);
    rd(`ADDR_STATUS);
    chk(rv & 32'h200, 32'h0);
    $display("test refuse done");
  endtask
  ////////////////////////////////////////
  // Main sequence after a four cycle reset
  initial begin
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_reset_set();
    t_set_test();
    t_switch();
    t_refuse();
    print_verdict();
  end
  // Watchdog: the whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    print_verdict();
  end
endmodule // flag_unit_tb_top
`default_nettype wire
